/* core/arx_receiver.sv */
// arx_receiver: serial return-to-zero word receiver with 16-bit tri-state read port
// assumes aclk far faster than line bits and gap clock; all pins but reset and axi4-lite are asynchronous
//
// Function
// - each recovered bit shifts into a 32-bit input register and checked words move in parallel to a buffer.
// - the host reads the buffer as two halves while the next word keeps shifting in.
// - the word-available flag rises on a new buffered word and falls when the first half read ends.
// - the output bus is driven only while the read strobe is low and is released otherwise.
// - with parity select high bit 32 carries an odd-parity error bit, else it passes unchanged.
// - the error output rises on a bit count other than 32 or on a parity error with checking on.
// - a low reset puts all internal state except the pin synchronisers into its initial value.
// - a word ends when no one or zero arrives for 16 to 17 gap-clock periods.
// - when either bypass input is high the bypass pair replaces the line pair.
// - a line-state latch is set by a one or zero and cleared by a null, giving the bit timing.
// - the first read returns bits 1 to 16 on lines 0 to 15 and the second bits 17 to 32.
// - every completed word overwrites the buffer and returns the half selector to the first half.
// - the error output clears on the next valid word loaded or on reset.
// - after reset nothing is accepted until the first word gap has passed.
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module arx_receiver #(
  parameter int WORD_BITS = arx_pkg::WORD_BITS,
  parameter int GAP_TICKS = arx_pkg::GAP_TICKS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // line and bypass pins
  input wire logic line_in_pos,
  input wire logic line_in_neg,
  input wire logic bypass_in_one,
  input wire logic bypass_in_zero,
  input wire logic word_gap_timebase,
  input wire logic parity_check_select,
  // parallel read port
  input wire logic read_n,
  output logic [arx_pkg::HALF_BITS-1:0] parallel_out_bus,
  output logic parallel_out_oe,
  output logic data_ready,
  output logic error_flag,
  // interrupt
  output logic irq,
  // axi4-lite write
  input wire logic [arx_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [arx_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int GAP_EDGES = GAP_TICKS + 1;
  localparam logic [arx_pkg::CNT_W-1:0] GAP_LAST = arx_pkg::CNT_W'(GAP_EDGES - 1);
  localparam logic [arx_pkg::CNT_W-1:0] FULL_CNT = arx_pkg::CNT_W'(WORD_BITS);
  localparam logic [arx_pkg::CNT_W-1:0] OVER_CNT = arx_pkg::CNT_W'(WORD_BITS + 1);

  // the half-word port and the saturating gap counter fix these limits
  if (WORD_BITS != 2 * arx_pkg::HALF_BITS || GAP_TICKS < 2 || GAP_EDGES >= (1 << arx_pkg::CNT_W)) begin
    $error("arx_receiver: unsupported parameters");
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [arx_pkg::NUM_PINS-1:0] pin_raw;
  logic [arx_pkg::NUM_PINS-1:0] sync1_r;
  logic [arx_pkg::NUM_PINS-1:0] pin_s;
  assign pin_raw = {parity_check_select, read_n, word_gap_timebase, bypass_in_zero, bypass_in_one,
                    line_in_neg, line_in_pos};
  genvar gi;
  generate
    for (gi = 0; gi < arx_pkg::NUM_PINS; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        sync1_r[gi] <= pin_raw[gi];
        pin_s[gi] <= sync1_r[gi];
      end
    end
  endgenerate

  // ****************************************
  // line decode and latch
  // ****************************************
  arx_pkg::arx_line_t line;
  logic bypass;
  logic valid;
  logic latch_r;
  logic bit_stb;
  logic gclk_d_r;
  logic gclk_rise;
  logic rd_d_r;
  logic rd_done;
  always_comb begin
    bypass = pin_s[arx_pkg::PIN_BYP1] | pin_s[arx_pkg::PIN_BYP0];
    if (bypass) begin
      line.one = pin_s[arx_pkg::PIN_BYP1] & ~pin_s[arx_pkg::PIN_BYP0];
      line.zero = pin_s[arx_pkg::PIN_BYP0] & ~pin_s[arx_pkg::PIN_BYP1];
    end else begin
      line.one = pin_s[arx_pkg::PIN_POS] & ~pin_s[arx_pkg::PIN_NEG];
      line.zero = pin_s[arx_pkg::PIN_NEG] & ~pin_s[arx_pkg::PIN_POS];
    end
  end
  assign valid = line.one | line.zero;
  assign bit_stb = valid & ~latch_r;
  assign gclk_rise = pin_s[arx_pkg::PIN_GCLK] & ~gclk_d_r;
  assign rd_done = pin_s[arx_pkg::PIN_RD] & ~rd_d_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_r <= 1'b0;
      gclk_d_r <= 1'b0;
      rd_d_r <= 1'b1;
    end else begin
      latch_r <= valid;
      gclk_d_r <= pin_s[arx_pkg::PIN_GCLK];
      rd_d_r <= pin_s[arx_pkg::PIN_RD];
    end
  end

  // ****************************************
  // gap timer
  // ****************************************
  // an extra edge is counted because the first edge after the null can come at once
  logic [arx_pkg::CNT_W-1:0] gap_cnt_r;
  logic gap_evt;
  assign gap_evt = gclk_rise & ~valid & (gap_cnt_r == GAP_LAST);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_cnt_r <= '0;
    end else if (valid) begin
      gap_cnt_r <= '0;
    end else if (gclk_rise && gap_cnt_r <= GAP_LAST) begin
      gap_cnt_r <= gap_cnt_r + 1'b1;
    end
  end

  // ****************************************
  // input register and word check
  // ****************************************
  arx_pkg::arx_state_t state_r;
  logic [WORD_BITS-1:0] shift_r;
  logic [arx_pkg::CNT_W-1:0] bit_cnt_r;
  logic len_ok;
  logic par_err;
  logic load;
  logic len_err;
  assign len_ok = bit_cnt_r == FULL_CNT;
  assign par_err = ~(^shift_r);
  assign load = (state_r == arx_pkg::ARX_RUN) & gap_evt & len_ok;
  assign len_err = (state_r == arx_pkg::ARX_RUN) & gap_evt & ~len_ok & (bit_cnt_r != '0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= arx_pkg::ARX_INIT;
    end else begin
      unique case (state_r)
        arx_pkg::ARX_INIT: begin
          if (gap_evt) begin
            state_r <= arx_pkg::ARX_RUN;
          end
        end
        arx_pkg::ARX_RUN: begin
          state_r <= arx_pkg::ARX_RUN;
        end
      endcase
    end
  end

  // first bit lands in bit 0 once 32 have been shifted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_r <= '0;
      bit_cnt_r <= '0;
    end else if (bit_stb) begin
      shift_r <= {line.one, shift_r[WORD_BITS-1:1]};
      if (bit_cnt_r != OVER_CNT) begin
        bit_cnt_r <= bit_cnt_r + 1'b1;
      end
    end else if (gap_evt) begin
      bit_cnt_r <= '0;
    end
  end

  // ****************************************
  // receive buffer, flags and read port
  // ****************************************
  logic [WORD_BITS-1:0] buf_r;
  arx_pkg::arx_flags_t flags;
  logic half_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_r <= '0;
    end else if (load) begin
      buf_r <= {pin_s[arx_pkg::PIN_PSEL] ? par_err : shift_r[WORD_BITS-1], shift_r[WORD_BITS-2:0]};
    end
  end

  // a load in the same cycle as a read end wins: the new word is not lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_ready <= 1'b0;
      half_r <= 1'b0;
    end else if (load) begin
      data_ready <= 1'b1;
      half_r <= 1'b0;
    end else if (rd_done) begin
      if (!half_r) begin
        data_ready <= 1'b0;
      end
      half_r <= ~half_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      error_flag <= 1'b0;
    end else if (load) begin
      error_flag <= pin_s[arx_pkg::PIN_PSEL] & par_err;
    end else if (len_err) begin
      error_flag <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      parallel_out_oe <= 1'b0;
      parallel_out_bus <= '0;
    end else begin
      parallel_out_oe <= ~pin_s[arx_pkg::PIN_RD];
      parallel_out_bus <= half_r ? buf_r[WORD_BITS-1:arx_pkg::HALF_BITS] : buf_r[arx_pkg::HALF_BITS-1:0];
    end
  end

  assign flags = '{armed: state_r == arx_pkg::ARX_RUN, half: half_r, error: error_flag, ready: data_ready};

  // ****************************************
  // interrupt status and mask
  // ****************************************
  logic [arx_pkg::IRQ_BITS-1:0] sts_r;
  logic [arx_pkg::IRQ_BITS-1:0] mask_r;
  logic [arx_pkg::IRQ_BITS-1:0] sts_set;
  logic [arx_pkg::IRQ_BITS-1:0] sts_clr;
  logic wr_go;
  logic [arx_pkg::ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic aw_held_r;
  logic w_held_r;
  assign wr_go = aw_held_r & w_held_r & ~s_axi_bvalid;
  always_comb begin
    sts_set = '0;
    sts_set[arx_pkg::ST_WORD] = load;
    sts_set[arx_pkg::ST_ERR] = len_err | (load & pin_s[arx_pkg::PIN_PSEL] & par_err);
    sts_clr = '0;
    if (wr_go && aw_addr_r == arx_pkg::REG_STATUS && w_strb_r[0]) begin
      sts_clr = w_data_r[arx_pkg::IRQ_BITS-1:0];
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sts_r <= arx_pkg::IRQ_RESET;
      mask_r <= arx_pkg::IRQ_RESET;
      irq <= 1'b0;
    end else begin
      sts_r <= (sts_r & ~sts_clr) | sts_set;
      if (wr_go && aw_addr_r == arx_pkg::REG_MASK && w_strb_r[0]) begin
        mask_r <= w_data_r[arx_pkg::IRQ_BITS-1:0];
      end
      irq <= |(sts_r & mask_r);
    end
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************
  logic wr_map;
  assign wr_map = aw_addr_r == arx_pkg::REG_STATUS || aw_addr_r == arx_pkg::REG_MASK;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= arx_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_r <= s_axi_awaddr;
        aw_held_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        w_held_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? arx_pkg::RESP_OKAY : arx_pkg::RESP_DECERR;
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= arx_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= arx_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        arx_pkg::REG_STATUS: s_axi_rdata <= 32'(sts_r);
        arx_pkg::REG_MASK: s_axi_rdata <= 32'(mask_r);
        arx_pkg::REG_WORD: s_axi_rdata <= 32'(buf_r);
        arx_pkg::REG_FLAGS: s_axi_rdata <= 32'(flags);
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= arx_pkg::RESP_DECERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_shift_in;
    bit_stb |=> shift_r[WORD_BITS-1] == $past(line.one);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("bit not shifted in");
  property p_ready_set;
    load |=> data_ready && half_r == 1'b0;
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("word ready or half wrong after load");
  property p_ready_clr;
    rd_done && !half_r && !load |=> !data_ready && half_r;
  endproperty
  a_ready_clr: assert property (p_ready_clr) else $error("ready not cleared by first read");
  property p_bus_enable;
    !pin_s[arx_pkg::PIN_RD] |=> parallel_out_oe ##1 (pin_s[arx_pkg::PIN_RD] || $past(pin_s[arx_pkg::PIN_RD]) || parallel_out_oe);
  endproperty
  a_bus_enable: assert property (p_bus_enable) else $error("bus not driven during read");
  property p_bus_order;
    !pin_s[arx_pkg::PIN_RD] && !load |=> parallel_out_bus == ($past(half_r) ? $past(buf_r[31:16]) : $past(buf_r[15:0]));
  endproperty
  a_bus_order: assert property (p_bus_order) else $error("wrong half on bus");
  property p_parity;
    load && pin_s[arx_pkg::PIN_PSEL] |=> buf_r[WORD_BITS-1] == ~(^$past(shift_r)) && error_flag == buf_r[WORD_BITS-1];
  endproperty
  a_parity: assert property (p_parity) else $error("parity bit or error wrong");
  property p_len_err;
    len_err |=> error_flag [*1] ##1 (error_flag || $past(load));
  endproperty
  a_len_err: assert property (p_len_err) else $error("length error not flagged");
  property p_err_clear;
    load && !pin_s[arx_pkg::PIN_PSEL] |=> !error_flag;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error not cleared by valid word");
  property p_gap;
    gap_evt |-> !valid && gap_cnt_r == GAP_LAST ##1 gap_cnt_r == GAP_LAST + 1'b1;
  endproperty
  a_gap: assert property (p_gap) else $error("gap fired early");
  property p_init;
    state_r == arx_pkg::ARX_INIT |-> !load ##1 !$rose(data_ready);
  endproperty
  a_init: assert property (p_init) else $error("word accepted before first gap");
  property p_reset;
    @(posedge aclk) disable iff (1'b0) !aresetn |=> state_r == arx_pkg::ARX_INIT && !data_ready && !error_flag;
  endproperty
  a_reset: assert property (p_reset) else $error("reset did not initialise");
  property p_bypass;
    bypass |-> line.one == (pin_s[arx_pkg::PIN_BYP1] && !pin_s[arx_pkg::PIN_BYP0]) && line.zero != line.one | !valid;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not selected");
  property p_latch;
    valid ##1 !valid |-> latch_r ##1 !latch_r;
  endproperty
  a_latch: assert property (p_latch) else $error("null did not clear latch");
endmodule

/* core/arx_pkg.sv */
// arx_pkg: constants and carrier types for the serial word receiver
// assumes a single aclk domain; pins are synchronised inside the receiver
package arx_pkg;
  // ****************************************
  // word and gap timing
  // ****************************************
  localparam int WORD_BITS = 32;
  localparam int HALF_BITS = 16;
  localparam int GAP_TICKS = 16;
  localparam int CNT_W = 6;
  // ****************************************
  // synchronised pin indices
  // ****************************************
  localparam int PIN_POS = 0;
  localparam int PIN_NEG = 1;
  localparam int PIN_BYP1 = 2;
  localparam int PIN_BYP0 = 3;
  localparam int PIN_GCLK = 4;
  localparam int PIN_RD = 5;
  localparam int PIN_PSEL = 6;
  localparam int NUM_PINS = 7;
  // ****************************************
  // register map and fields
  // ****************************************
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_MASK = 4'h4;
  localparam logic [3:0] REG_WORD = 4'h8;
  localparam logic [3:0] REG_FLAGS = 4'hC;
  localparam int IRQ_BITS = 2;
  localparam int ST_WORD = 0;
  localparam int ST_ERR = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef struct packed {
    logic one;
    logic zero;
  } arx_line_t;
  typedef struct packed {
    logic armed;
    logic half;
    logic error;
    logic ready;
  } arx_flags_t;
  typedef enum logic [1:0] {
    ARX_INIT = 2'b01,
    ARX_RUN = 2'b10
  } arx_state_t;
endpackage

/* verification/arx_line_model.sv */
// arx_line_model: remote return-to-zero transmitter and gap timebase for the receiver bench
// assumes the bench calls send from one process, one word at a time
`timescale 1ns/1ps
module arx_line_model #(
  parameter int GAP_HALF = 8
) (
  // clock
  input wire logic aclk,
  // line side
  output logic line_in_pos,
  output logic line_in_neg,
  output logic bypass_in_one,
  output logic bypass_in_zero,
  output logic word_gap_timebase
);
  int gcnt = 0;
  initial begin
    {line_in_pos, line_in_neg, bypass_in_one, bypass_in_zero} = 4'h0;
    word_gap_timebase = 1'b0;
  end
  // ****************************************
  // gap timebase
  // ****************************************
  // free running and far slower than aclk, so the gap timeout outlasts the null after each bit
  always @(posedge aclk) begin
    gcnt <= (gcnt == GAP_HALF - 1) ? 0 : gcnt + 1;
    if (gcnt == GAP_HALF - 1) begin
      word_gap_timebase <= ~word_gap_timebase;
    end
  end
  // ****************************************
  // word sender
  // ****************************************
  // null after every bit, so each bit is a fresh null to valid edge
  task automatic send(input logic [31:0] w, input int n, input logic byp);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      if (byp) begin
        bypass_in_one <= w[i % 32];
        bypass_in_zero <= ~w[i % 32];
      end else begin
        line_in_pos <= w[i % 32];
        line_in_neg <= ~w[i % 32];
      end
      repeat (4) @(posedge aclk);
      {line_in_pos, line_in_neg, bypass_in_one, bypass_in_zero} <= 4'h0;
      repeat (3) @(posedge aclk);
    end
  endtask
endmodule

/* verification/testbench.sv */
// testbench: directed checks of the serial word receiver through pins and axi4-lite
// assumes arx_receiver and arx_line_model; the gap count is shortened to keep the run brief
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module testbench;
  localparam int GT = 4;
  localparam int GP = 16;
  logic aclk = 1'b0, aresetn = 1'b0, psel = 1'b0, read_n = 1'b1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, oe, dr, err, irq, pos, neg, b1, b0, gclk;
  logic [1:0] bresp, rresp, rsp;
  logic [15:0] pbus, h0, h1;
  logic [31:0] pw [2] = '{32'h8000_0001, 32'h8000_0000};
  int ln [2] = '{31, 33};
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  wire [15:0] dbus;
  // bus wire resolved from the device enable; nobody else drives it
  assign dbus = oe ? pbus : 16'hZZZZ;
  always #4 aclk = ~aclk;
  arx_line_model #(.GAP_HALF(GP / 2)) arx_line_model_inst (.aclk(aclk), .line_in_pos(pos),
    .line_in_neg(neg), .bypass_in_one(b1), .bypass_in_zero(b0), .word_gap_timebase(gclk));
  arx_receiver #(.GAP_TICKS(GT)) arx_receiver_inst (.aclk(aclk), .aresetn(aresetn),
    .line_in_pos(pos), .line_in_neg(neg), .bypass_in_one(b1), .bypass_in_zero(b0),
    .word_gap_timebase(gclk), .parity_check_select(psel), .read_n(read_n),
    .parallel_out_bus(pbus), .parallel_out_oe(oe), .data_ready(dr), .error_flag(err), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  // ****************************************
  // closing and timeout
  // ****************************************
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  // ****************************************
  // access tasks
  // ****************************************
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, d, 4'hF};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  task automatic rd_half(output logic [15:0] h);
    @(posedge aclk);
    read_n <= 1'b0;
    repeat (5) @(posedge aclk);
    h = dbus;
    `CHK("oe in strobe", 1'b1, oe)
    read_n <= 1'b1;
    repeat (5) @(posedge aclk);
    `CHK("oe released", 1'b0, oe)
  endtask
  task automatic chk_word(input logic [31:0] e);
    rd_half(h0);
    `CHK("ready after first half", 1'b0, dr)
    rd_half(h1);
    `CHK("first half", e[15:0], h0)
    `CHK("second half", e[31:16], h1)
  endtask
  // send, then prove the load has not shown GT - 1 gap-clock periods into the gap
  task automatic word(input logic [31:0] w, input int n, input logic byp);
    logic d0;
    d0 = dr;
    arx_line_model_inst.send(w, n, byp);
    repeat ((GT - 1) * GP) @(posedge aclk);
    if (!d0) `CHK("no early load", 1'b0, dr)
    repeat (3 * GP) @(posedge aclk);
  endtask
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("ready after reset", 1'b0, dr)
    `CHK("error after reset", 1'b0, err)
    `CHK("irq after reset", 1'b0, irq)
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    do_reset();
    word(32'hA5A5_0F0F, 32, 1'b0);
    `CHK("word before first gap", 1'b0, dr)
    $display("test arm done");
    word(32'h8000_1235, 32, 1'b0);
    `CHK("ready on load", 1'b1, dr)
    `CHK("no error", 1'b0, err)
    axi_rd(arx_pkg::REG_WORD);
    `CHK("buffer word", 32'h8000_1235, v)
    chk_word(32'h8000_1235);
    $display("test plain done");
    psel <= 1'b1;
    foreach (pw[i]) begin
      word(pw[i], 32, 1'b0);
      `CHK("parity error flag", ~^pw[i], err)
      chk_word({~^pw[i], pw[i][30:0]});
    end
    psel <= 1'b0;
    $display("test parity done");
    foreach (ln[i]) begin
      word(32'h0000_FFFF, ln[i], 1'b0);
      `CHK("length error", 1'b1, err)
      `CHK("bad length not loaded", 1'b0, dr)
    end
    $display("test length done");
    axi_rd(arx_pkg::REG_STATUS);
    `CHK("status events", 2'h3, v[1:0])
    axi_wr(arx_pkg::REG_STATUS, 32'h3);
    `CHK("write resp", arx_pkg::RESP_OKAY, rsp)
    axi_rd(arx_pkg::REG_STATUS);
    `CHK("status cleared", 2'h0, v[1:0])
    axi_wr(arx_pkg::REG_MASK, 32'h1);
    axi_rd(arx_pkg::REG_MASK);
    `CHK("mask readback", 2'h1, v[1:0])
    `CHK("irq masked idle", 1'b0, irq)
    word(32'h1357_9BDF, 32, 1'b1);
    `CHK("valid word clears error", 1'b0, err)
    `CHK("irq on load", 1'b1, irq)
    chk_word(32'h1357_9BDF);
    axi_wr(arx_pkg::REG_STATUS, 32'h1);
    repeat (3) @(posedge aclk);
    `CHK("irq cleared", 1'b0, irq)
    axi_rd(4'h2);
    `CHK("unmapped resp", arx_pkg::RESP_DECERR, rsp)
    axi_wr(4'h2, 32'h0);
    `CHK("unmapped write resp", arx_pkg::RESP_DECERR, rsp)
    $display("test irq and bypass done");
    word(32'h1111_2222, 32, 1'b0);
    word(32'h3333_4444, 32, 1'b0);
    axi_rd(arx_pkg::REG_FLAGS);
    `CHK("flags armed and ready", 4'h9, v[3:0])
    chk_word(32'h3333_4444);
    word(32'h5555_6666, 32, 1'b0);
    // first half is read while the next word is still shifting in
    fork
      rd_half(h0);
      word(32'h7777_8888, 32, 1'b0);
    join
    `CHK("first half while shifting", 16'h6666, h0)
    `CHK("ready on overwrite", 1'b1, dr)
    chk_word(32'h7777_8888);
    $display("test overwrite done");
    word(32'h0000_0001, 31, 1'b0);
    `CHK("error before reset", 1'b1, err)
    do_reset();
    $display("test reset done");
    results();
  end
endmodule
